/* File: design/rcce_cfg.svh */
// Purpose: Constants of the execution core: vectors, fields, opcodes.
// Assumes: Included by rcce_core and the testbench top by its bare name.
// Notes: Opcode map and vector table are fixed for this core.
`ifndef RCCE_CFG_SVH
`define RCCE_CFG_SVH
// Exception vectors
`define RCCE_VEC_RESET 32'h0000_0000
`define RCCE_VEC_BUSERR 32'h0000_0100
`define RCCE_VEC_IRQ 32'h0000_0200
`define RCCE_VEC_ILLEGAL 32'h0000_0300
// Instruction fields
`define RCCE_OPC 31:26
`define RCCE_RD 25:21
`define RCCE_RA 20:16
`define RCCE_RB 15:11
`define RCCE_IMM 15:0
`define RCCE_FN 3:0
`define RCCE_JOFF 25:0
// Opcodes; op[5:4] of 2'h1 is register-immediate ALU, fn in op[3:0]
`define RCCE_OP_ALUR 6'h00
`define RCCE_OP_ALUI 2'h1
`define RCCE_OP_LBZ 6'h20
`define RCCE_OP_LHZ 6'h21
`define RCCE_OP_LW 6'h22
`define RCCE_OP_LBS 6'h23
`define RCCE_OP_LHS 6'h24
`define RCCE_OP_SB 6'h28
`define RCCE_OP_SH 6'h29
`define RCCE_OP_SW 6'h2A
`define RCCE_OP_BF 6'h30
`define RCCE_OP_BNF 6'h31
`define RCCE_OP_J 6'h32
`define RCCE_OP_JR 6'h33
`define RCCE_OP_JAL 6'h34
`define RCCE_OP_MFSPR 6'h38
`define RCCE_OP_MTSPR 6'h39
`define RCCE_OP_RFE 6'h3A
`define RCCE_OP_DOZE 6'h3B
// Special registers and status bits
`define RCCE_SPR_SR 16'h0000
`define RCCE_SPR_EPC 16'h0001
`define RCCE_SPR_ESR 16'h0002
`define RCCE_SPR_EEAR 16'h0003
`define RCCE_SR_IE 0
`define RCCE_SR_F 1
`define RCCE_SR_RESET 32'h0000_0000
// Misc
`define RCCE_LINK_REG 5'h1F
`define RCCE_PC_STEP 32'h0000_0004
`define RCCE_BE_ALL 4'hF
`define RCCE_BE_NONE 4'h0
`define RCCE_BE_B0 4'h8
`define RCCE_BE_H0 4'hC
`endif

/* File: design/rcce_pkg.sv */
// Purpose: Types shared by the execution core modules.
// Assumes: Nothing.
// Notes: State codes are one-hot.
package rcce_pkg;
    typedef enum logic [3:0] {
        RCCE_ST_RESET = 4'h1,
        RCCE_ST_EXEC = 4'h2,
        RCCE_ST_MEM = 4'h4,
        RCCE_ST_DOZE = 4'h8
    } rcce_state_t;
    typedef enum logic [3:0] {
        RCCE_ADD = 4'h0, RCCE_SUB = 4'h1, RCCE_AND = 4'h2, RCCE_OR = 4'h3,
        RCCE_XOR = 4'h4, RCCE_SLL = 4'h5, RCCE_SRL = 4'h6, RCCE_SRA = 4'h7,
        RCCE_ROR = 4'h8, RCCE_EQ = 4'h9, RCCE_LTS = 4'hA, RCCE_LTU = 4'hB,
        RCCE_MOVHI = 4'hC
    } rcce_alu_fn_t;
    typedef enum logic [1:0] {
        RCCE_SZ_B = 2'h0,
        RCCE_SZ_H = 2'h1,
        RCCE_SZ_W = 2'h2
    } rcce_size_t;
endpackage

/* File: design/rcce_alu.sv */
// Purpose: Combinational ALU of the execution core.
// Assumes: Operands already selected by the core.
// Notes: Compares return 0 or 1 and also raise cmp for the flag.
`timescale 1ns/1ps
module rcce_alu import rcce_pkg::*; (
    // Operands
    input wire logic [31:0] a,
    input wire logic [31:0] b,
    input wire rcce_alu_fn_t fn,
    // Result
    output logic [31:0] y,
    output logic flag,
    output logic cmp
);
    always_comb begin
        y = 32'h0000_0000;
        flag = 1'b0;
        cmp = 1'b0;
        case (fn)
            RCCE_ADD: y = a + b;
            RCCE_SUB: y = a - b;
            RCCE_AND: y = a & b;
            RCCE_OR: y = a | b;
            RCCE_XOR: y = a ^ b;
            RCCE_SLL: y = a << b[4:0];
            RCCE_SRL: y = a >> b[4:0];
            RCCE_SRA: y = $signed(a) >>> b[4:0];
            RCCE_ROR: y = (a >> b[4:0]) | (a << (6'h20 - {1'b0, b[4:0]}));
            RCCE_EQ: begin
                cmp = 1'b1;
                flag = (a == b);
            end
            RCCE_LTS: begin
                cmp = 1'b1;
                flag = ($signed(a) < $signed(b));
            end
            RCCE_LTU: begin
                cmp = 1'b1;
                flag = (a < b);
            end
            RCCE_MOVHI: y = {b[15:0], 16'h0000};
            default: y = 32'h0000_0000;
        endcase
        if (cmp) begin
            y = {31'h0000_0000, flag};
        end
    end
endmodule

/* File: design/rcce_regs.sv */
// Purpose: Thirty-two 32-bit general registers, two reads, one write.
// Assumes: Reads are combinational; write lands at the clock edge.
// Notes: Storage has no reset; software must initialise what it reads.
`timescale 1ns/1ps
module rcce_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Read ports
    input wire logic [4:0] ra_addr,
    input wire logic [4:0] rb_addr,
    output logic [31:0] ra_data,
    output logic [31:0] rb_data,
    // Write port
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire logic [31:0] wdata
);
    logic [31:0] mem [32];

    assign ra_data = mem[ra_addr];
    assign rb_data = mem[rb_addr];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    property p_reg_write;
        @(posedge clk) disable iff (!reset_n)
        we |=> mem[$past(waddr)] == $past(wdata);
    endproperty
    a_reg_write: assert property (p_reg_write)
        else $error("general register lost a write");
endmodule

/* File: design/rcce_core.sv */
// Purpose: 32-bit load/store execution core with exceptions and doze.
// Assumes: Memory answers combinationally while mem_req is high.
// Notes: One cycle per register op, two per load or store.
`timescale 1ns/1ps
`include "rcce_cfg.svh"

// Summary of operation
// - Thirty-two 32-bit general registers plus special registers
// - Only loads and stores move memory data
// - ALU ops: two registers or register+constant
// - Register-only operations finish in one cycle
// - Memory instructions take one extra cycle
// - Byte, half, word accesses, big-endian lanes
// - Fetch and data share one address space
// - Peripherals reached by plain loads and stores
// - Any register serves as base address
// - Reset and interrupts use one exception path
// - Exception copies PC and status in one cycle
// - PC takes vector; handler runs next cycle
// - Doze stops execution until an interrupt
// - Faulting access raises a bus error exception
// - Reset starts at reset vector, known state
module rcce_core import rcce_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Unified memory bus
    output logic mem_req,
    output logic mem_we,
    output logic [3:0] mem_be,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_rdy,
    input wire logic mem_err,
    // Events
    input wire logic irq,
    output logic dozing
);
    ////////////////////////////////////////////////////////////////////
    function automatic logic is_alu(input logic [5:0] op);
        return (op == `RCCE_OP_ALUR) || (op[5:4] == `RCCE_OP_ALUI);
    endfunction

    function automatic logic is_load(input logic [5:0] op);
        return (op >= `RCCE_OP_LBZ) && (op <= `RCCE_OP_LHS);
    endfunction

    function automatic logic is_store(input logic [5:0] op);
        return (op >= `RCCE_OP_SB) && (op <= `RCCE_OP_SW);
    endfunction

    function automatic rcce_size_t size_of(input logic [5:0] op);
        rcce_size_t s;
        s = RCCE_SZ_W;
        if (op == `RCCE_OP_LBZ || op == `RCCE_OP_LBS ||
            op == `RCCE_OP_SB) begin
            s = RCCE_SZ_B;
        end else if (op == `RCCE_OP_LHZ || op == `RCCE_OP_LHS ||
                     op == `RCCE_OP_SH) begin
            s = RCCE_SZ_H;
        end
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////
    rcce_state_t state_q, state_d;
    logic [31:0] pc_q, pc_d, ir_q, ir_d, sr_q, sr_d;
    logic [31:0] epc_q, epc_d, esr_q, esr_d, eear_q, eear_d;
    logic mem_req_q, mem_req_d, mem_we_q, mem_we_d, dozing_q, dozing_d;
    logic [3:0] mem_be_q, mem_be_d;
    logic [31:0] mem_addr_q, mem_addr_d, mem_wdata_q, mem_wdata_d;

    logic [31:0] insn, imm_s, imm_z, ra_data, rb_data, alu_b, alu_y;
    logic [31:0] ea, pc_next, tgt, spr_val, ld_shift, ld_val;
    logic [31:0] exc_vec, exc_epc, exc_addr, rf_wdata;
    logic [5:0] opc, ir_opc;
    logic [4:0] rb_sel, rf_waddr;
    logic [3:0] lane_be;
    logic alu_flag, alu_cmp, rf_we, exc_take, misalign, go, jump;
    rcce_alu_fn_t alu_fn;
    rcce_size_t sz;

    // Instruction comes straight off the shared bus
    assign insn = mem_rdata;
    assign opc = insn[`RCCE_OPC];
    assign ir_opc = ir_q[`RCCE_OPC];
    assign imm_s = {{16{insn[15]}}, insn[`RCCE_IMM]};
    assign imm_z = {16'h0000, insn[`RCCE_IMM]};
    assign pc_next = pc_q + `RCCE_PC_STEP;
    // Stores read their data register through the second port
    assign rb_sel = is_store(opc) ? insn[`RCCE_RD] : insn[`RCCE_RB];
    assign alu_fn = rcce_alu_fn_t'((opc == `RCCE_OP_ALUR) ?
                    insn[`RCCE_FN] : opc[3:0]);
    // Logical ops zero-extend their constant, the rest sign-extend
    assign alu_b = (opc == `RCCE_OP_ALUR) ? rb_data :
        ((alu_fn == RCCE_AND || alu_fn == RCCE_OR || alu_fn == RCCE_XOR)
         ? imm_z : imm_s);
    assign ea = ra_data + imm_s;
    assign sz = size_of(opc);
    assign misalign = (sz == RCCE_SZ_H && ea[0]) ||
                      (sz == RCCE_SZ_W && ea[1:0] != 2'b00);
    // Big-endian: byte offset 0 sits in bits 31:24
    assign lane_be = (sz == RCCE_SZ_B) ? (`RCCE_BE_B0 >> ea[1:0]) :
                     (sz == RCCE_SZ_H) ? (`RCCE_BE_H0 >> {ea[1], 1'b0}) :
                     `RCCE_BE_ALL;
    assign ld_shift = (size_of(ir_opc) == RCCE_SZ_B) ?
        (mem_rdata >> {~mem_addr_q[1:0], 3'b000}) :
        (mem_rdata >> {~mem_addr_q[1], 4'h0});

    always_comb begin
        case (ir_opc)
            `RCCE_OP_LBZ: ld_val = {24'h00_0000, ld_shift[7:0]};
            `RCCE_OP_LBS: ld_val = {{24{ld_shift[7]}}, ld_shift[7:0]};
            `RCCE_OP_LHZ: ld_val = {16'h0000, ld_shift[15:0]};
            `RCCE_OP_LHS: ld_val = {{16{ld_shift[15]}}, ld_shift[15:0]};
            default: ld_val = mem_rdata;
        endcase
        case (insn[`RCCE_IMM])
            `RCCE_SPR_SR: spr_val = sr_q;
            `RCCE_SPR_EPC: spr_val = epc_q;
            `RCCE_SPR_ESR: spr_val = esr_q;
            `RCCE_SPR_EEAR: spr_val = eear_q;
            default: spr_val = 32'h0000_0000;
        endcase
    end

    rcce_regs u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .ra_addr(insn[`RCCE_RA]),
        .rb_addr(rb_sel),
        .ra_data(ra_data),
        .rb_data(rb_data),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata)
    );

    rcce_alu u_alu (
        .a(ra_data),
        .b(alu_b),
        .fn(alu_fn),
        .y(alu_y),
        .flag(alu_flag),
        .cmp(alu_cmp)
    );

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        ir_d = ir_q;
        sr_d = sr_q;
        epc_d = epc_q;
        esr_d = esr_q;
        eear_d = eear_q;
        mem_req_d = mem_req_q;
        mem_we_d = mem_we_q;
        mem_be_d = mem_be_q;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        dozing_d = dozing_q;
        rf_we = 1'b0;
        rf_waddr = insn[`RCCE_RD];
        rf_wdata = alu_y;
        exc_take = 1'b0;
        exc_vec = `RCCE_VEC_IRQ;
        exc_epc = pc_q;
        exc_addr = pc_q;
        tgt = pc_next;
        go = 1'b0;
        jump = 1'b1;
        case (state_q)
            RCCE_ST_RESET: begin
                exc_take = 1'b1;
                exc_vec = `RCCE_VEC_RESET;
            end
            RCCE_ST_EXEC: begin
                if (!mem_rdy) begin
                    jump = 1'b0;
                end else if (mem_err) begin
                    exc_take = 1'b1;
                    exc_vec = `RCCE_VEC_BUSERR;
                end else if (irq && sr_q[`RCCE_SR_IE]) begin
                    exc_take = 1'b1;
                end else if (is_alu(opc)) begin
                    go = 1'b1;
                    rf_we = 1'b1;
                    if (alu_cmp) begin
                        sr_d[`RCCE_SR_F] = alu_flag;
                    end
                end else if (is_load(opc) || is_store(opc)) begin
                    jump = 1'b0;
                    if (misalign) begin
                        exc_take = 1'b1;
                        exc_vec = `RCCE_VEC_BUSERR;
                        exc_addr = ea;
                    end else begin
                        // Hold the fetch one cycle for the data access
                        ir_d = insn;
                        state_d = RCCE_ST_MEM;
                        mem_addr_d = ea;
                        mem_we_d = is_store(opc);
                        mem_be_d = lane_be;
                        mem_wdata_d = (sz == RCCE_SZ_B) ? {4{rb_data[7:0]}} :
                            (sz == RCCE_SZ_H) ? {2{rb_data[15:0]}} : rb_data;
                    end
                end else begin
                    case (opc)
                        `RCCE_OP_BF: if (sr_q[`RCCE_SR_F]) begin
                            tgt = pc_next + {imm_s[29:0], 2'b00};
                        end
                        `RCCE_OP_BNF: if (!sr_q[`RCCE_SR_F]) begin
                            tgt = pc_next + {imm_s[29:0], 2'b00};
                        end
                        `RCCE_OP_J: tgt = pc_q +
                            {{4{insn[25]}}, insn[`RCCE_JOFF], 2'b00};
                        `RCCE_OP_JR: tgt = ra_data;
                        `RCCE_OP_JAL: begin
                            tgt = pc_q +
                                {{4{insn[25]}}, insn[`RCCE_JOFF], 2'b00};
                            rf_we = 1'b1;
                            rf_waddr = `RCCE_LINK_REG;
                            rf_wdata = pc_next;
                        end
                        `RCCE_OP_MFSPR: begin
                            rf_we = 1'b1;
                            rf_wdata = spr_val;
                        end
                        `RCCE_OP_MTSPR: begin
                            case (insn[`RCCE_IMM])
                                `RCCE_SPR_SR: sr_d = ra_data;
                                `RCCE_SPR_EPC: epc_d = ra_data;
                                `RCCE_SPR_ESR: esr_d = ra_data;
                                `RCCE_SPR_EEAR: eear_d = ra_data;
                                default: sr_d = sr_q;
                            endcase
                        end
                        `RCCE_OP_RFE: begin
                            tgt = epc_q;
                            sr_d = esr_q;
                        end
                        `RCCE_OP_DOZE: begin
                            // Bus goes quiet; pc already points past
                            jump = 1'b0;
                            pc_d = pc_next;
                            mem_req_d = 1'b0;
                            dozing_d = 1'b1;
                            state_d = RCCE_ST_DOZE;
                        end
                        default: begin
                            exc_take = 1'b1;
                            exc_vec = `RCCE_VEC_ILLEGAL;
                        end
                    endcase
                end
            end
            RCCE_ST_MEM: begin
                if (!mem_rdy) begin
                    jump = 1'b0;
                end else if (mem_err) begin
                    exc_take = 1'b1;
                    exc_vec = `RCCE_VEC_BUSERR;
                    exc_addr = mem_addr_q;
                end else begin
                    if (is_load(ir_opc)) begin
                        rf_we = 1'b1;
                        rf_waddr = ir_q[`RCCE_RD];
                        rf_wdata = ld_val;
                    end
                    state_d = RCCE_ST_EXEC;
                    mem_we_d = 1'b0;
                    mem_be_d = `RCCE_BE_ALL;
                end
            end
            RCCE_ST_DOZE: begin
                jump = 1'b0;
                if (irq) begin
                    dozing_d = 1'b0;
                    if (sr_q[`RCCE_SR_IE]) begin
                        exc_take = 1'b1;
                    end else begin
                        state_d = RCCE_ST_EXEC;
                        mem_req_d = 1'b1;
                        mem_addr_d = pc_q;
                    end
                end
            end
            default: begin
                jump = 1'b0;
                state_d = RCCE_ST_RESET;
            end
        endcase
        if (jump && !exc_take) begin
            pc_d = tgt;
            mem_addr_d = tgt;
        end
        if (exc_take) begin
            rf_we = 1'b0;
            epc_d = exc_epc;
            esr_d = sr_q;
            eear_d = exc_addr;
            sr_d[`RCCE_SR_IE] = 1'b0;
            pc_d = exc_vec;
            mem_addr_d = exc_vec;
            mem_req_d = 1'b1;
            mem_we_d = 1'b0;
            mem_be_d = `RCCE_BE_ALL;
            dozing_d = 1'b0;
            state_d = RCCE_ST_EXEC;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= RCCE_ST_RESET;
            pc_q <= `RCCE_VEC_RESET;
            ir_q <= 32'h0000_0000;
            sr_q <= `RCCE_SR_RESET;
            epc_q <= 32'h0000_0000;
            esr_q <= 32'h0000_0000;
            eear_q <= 32'h0000_0000;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_be_q <= `RCCE_BE_NONE;
            mem_addr_q <= `RCCE_VEC_RESET;
            mem_wdata_q <= 32'h0000_0000;
            dozing_q <= 1'b0;
        end else begin
            state_q <= state_d;
            pc_q <= pc_d;
            ir_q <= ir_d;
            sr_q <= sr_d;
            epc_q <= epc_d;
            esr_q <= esr_d;
            eear_q <= eear_d;
            mem_req_q <= mem_req_d;
            mem_we_q <= mem_we_d;
            mem_be_q <= mem_be_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
            dozing_q <= dozing_d;
        end
    end

    assign mem_req = mem_req_q;
    assign mem_we = mem_we_q;
    assign mem_be = mem_be_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;
    assign dozing = dozing_q;

    ////////////////////////////////////////////////////////////////////
    property p_one_cycle;
        @(posedge clk) disable iff (!reset_n)
        go |=> state_q == RCCE_ST_EXEC &&
               mem_addr_q == $past(pc_q) + `RCCE_PC_STEP;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("register op did not finish in one cycle");

    property p_mem_extra;
        @(posedge clk) disable iff (!reset_n)
        (state_q == RCCE_ST_EXEC && state_d == RCCE_ST_MEM)
        |=> mem_addr_q == $past(ea) ##1
            (state_q == RCCE_ST_EXEC || !$past(mem_rdy) || exc_take ||
             $past(mem_err));
    endproperty
    a_mem_extra: assert property (p_mem_extra)
        else $error("memory access did not take exactly one extra cycle");

    property p_byte_lane;
        @(posedge clk) disable iff (!reset_n)
        (state_d == RCCE_ST_MEM && state_q == RCCE_ST_EXEC &&
         opc == `RCCE_OP_SB)
        |=> mem_be_q == (`RCCE_BE_B0 >> mem_addr_q[1:0]) && mem_we_q;
    endproperty
    a_byte_lane: assert property (p_byte_lane)
        else $error("store byte not on its big-endian lane");

    property p_exc_save;
        @(posedge clk) disable iff (!reset_n)
        exc_take |=> epc_q == $past(exc_epc) && esr_q == $past(sr_q) &&
                     !sr_q[`RCCE_SR_IE];
    endproperty
    a_exc_save: assert property (p_exc_save)
        else $error("exception state not saved in one cycle");

    property p_exc_vec;
        @(posedge clk) disable iff (!reset_n)
        exc_take |=> pc_q == $past(exc_vec) && mem_addr_q == pc_q &&
                     mem_req_q && state_q == RCCE_ST_EXEC;
    endproperty
    a_exc_vec: assert property (p_exc_vec)
        else $error("vector not fetched the cycle after exception");

    property p_doze_hold;
        @(posedge clk) disable iff (!reset_n)
        (state_q == RCCE_ST_DOZE && !irq) |=> !mem_req_q && dozing_q;
    endproperty
    a_doze_hold: assert property (p_doze_hold)
        else $error("core left doze without an interrupt");

    property p_doze_wake;
        @(posedge clk) disable iff (!reset_n)
        (state_q == RCCE_ST_DOZE && irq) |=>
            state_q == RCCE_ST_EXEC && mem_req_q && !dozing_q;
    endproperty
    a_doze_wake: assert property (p_doze_wake)
        else $error("interrupt did not wake the core");

    property p_bus_err;
        @(posedge clk) disable iff (!reset_n)
        (state_q == RCCE_ST_MEM && mem_rdy && mem_err) |=>
            pc_q == `RCCE_VEC_BUSERR && eear_q == $past(mem_addr_q);
    endproperty
    a_bus_err: assert property (p_bus_err)
        else $error("bus error did not vector");

    property p_reset_start;
        @(posedge clk) disable iff (!reset_n)
        state_q == RCCE_ST_RESET |=> pc_q == `RCCE_VEC_RESET &&
            mem_addr_q == `RCCE_VEC_RESET && sr_q == `RCCE_SR_RESET;
    endproperty
    a_reset_start: assert property (p_reset_start)
        else $error("reset did not start at the reset vector");
endmodule

/* File: testbench/rcce_mem.sv */
// Purpose: Memory partner answering the core bus, with optional stalls.
// Assumes: Byte addresses 0x000-0x7FF (512 words) populated; all else faults.
// Notes: Idle read data flips every cycle so stale values are not trusted.
`timescale 1ns/1ps
module rcce_mem (
    // Clock and stall control
    input wire logic clk,
    input wire logic slow,
    // Memory bus
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_rdy,
    output logic mem_err
);
    logic [31:0] mem [0:511];
    logic [31:0] last_q = 32'h0000_0000;
    logic tog_q = 1'b0;
    logic hit;
    assign hit = mem_addr < 32'h0000_0800;
    // Slow mode answers every other cycle to prove the core waits
    assign mem_rdy = mem_req && (!slow || tog_q);
    assign mem_err = mem_rdy && !hit;
    assign mem_rdata = (mem_rdy && hit) ? mem[mem_addr[10:2]] : ~last_q;
    always_ff @(posedge clk) begin
        tog_q <= !tog_q;
        last_q <= mem_rdata;
        if (mem_rdy && hit && mem_we) begin
            for (int k = 0; k < 4; k++) begin
                if (mem_be[3 - k]) begin
                    mem[mem_addr[10:2]][31 - 8 * k -: 8] <=
                        mem_wdata[31 - 8 * k -: 8];
                end
            end
        end
    end
endmodule

/* File: testbench/risc_cpu_core_exec_tb_top.sv */
// Purpose: Runs a small program through the core, fast and stalled.
// Assumes: Program is placed in the partner memory during reset.
// Notes: Results are read back from memory, so stores carry the data checks; bus signals are checked directly.
`timescale 1ns/1ps
`include "rcce_cfg.svh"
module risc_cpu_core_exec_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic irq = 1'b0;
    logic slow = 1'b0;
    logic mem_req, mem_we, mem_rdy, mem_err, dozing;
    logic [3:0] mem_be;
    logic [31:0] mem_addr, mem_wdata, mem_rdata;
    int err_count = 0;
    int checks_done = 0;
    int xfers = 0;
    rcce_core u_rcce_core (.clk(clk), .reset_n(reset_n), .mem_req(mem_req),
        .mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rdy(mem_rdy),
        .mem_err(mem_err), .irq(irq), .dozing(dozing));
    rcce_mem u_rcce_mem (.clk(clk), .slow(slow), .mem_req(mem_req),
        .mem_we(mem_we), .mem_be(mem_be), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_rdy(mem_rdy),
        .mem_err(mem_err));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) xfers <= 0;
        else if (mem_req === 1'b1 && mem_rdy === 1'b1) xfers <= xfers + 1;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    function automatic logic [31:0] enc(input logic [5:0] op,
        input logic [4:0] rd, input logic [4:0] ra, input logic [15:0] im);
        return {op, rd, ra, im};
    endfunction
    task automatic wait_doze(input logic lvl);
        for (int i = 0; i < 400 && dozing !== lvl; i++) begin
            @(posedge clk);
            #1;
        end
        if (dozing !== lvl) begin
            err_count++;
            close_out();
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic load_prog();
        for (int i = 0; i < 512; i++) u_rcce_mem.mem[i] = 32'h0000_0000;
        u_rcce_mem.mem[0] = enc(6'h1C, 5'h01, 5'h00, 16'h1234);
        u_rcce_mem.mem[1] = enc(6'h13, 5'h01, 5'h01, 16'h5678);
        u_rcce_mem.mem[2] = enc(6'h1C, 5'h02, 5'h00, 16'h0000);
        u_rcce_mem.mem[3] = enc(`RCCE_OP_SW, 5'h01, 5'h02, 16'h0400);
        u_rcce_mem.mem[4] = enc(`RCCE_OP_SB, 5'h01, 5'h02, 16'h0405);
        u_rcce_mem.mem[5] = enc(`RCCE_OP_LHZ, 5'h03, 5'h02, 16'h0402);
        u_rcce_mem.mem[6] = enc(`RCCE_OP_SW, 5'h03, 5'h02, 16'h0408);
        // Negative displacement lands outside populated memory
        u_rcce_mem.mem[7] = enc(`RCCE_OP_LW, 5'h04, 5'h02, 16'h8000);
        u_rcce_mem.mem[64] = enc(`RCCE_OP_MFSPR, 5'h05, 5'h00, 16'h0003);
        u_rcce_mem.mem[65] = enc(`RCCE_OP_SW, 5'h05, 5'h02, 16'h040C);
        u_rcce_mem.mem[66] = enc(6'h13, 5'h06, 5'h02, 16'h0001);
        u_rcce_mem.mem[67] = enc(`RCCE_OP_MTSPR, 5'h00, 5'h06, 16'h0000);
        u_rcce_mem.mem[68] = enc(`RCCE_OP_DOZE, 5'h00, 5'h00, 16'h0000);
        u_rcce_mem.mem[128] = enc(`RCCE_OP_MFSPR, 5'h07, 5'h00, 16'h0001);
        u_rcce_mem.mem[129] = enc(`RCCE_OP_SW, 5'h07, 5'h02, 16'h0410);
        u_rcce_mem.mem[130] = enc(`RCCE_OP_DOZE, 5'h00, 5'h00, 16'h0000);
    endtask
    task automatic test_program(input logic s);
        @(posedge clk);
        reset_n <= 1'b0;
        slow <= s;
        load_prog();
        repeat (4) @(posedge clk);
        check("req in reset", {31'h0, mem_req}, 32'h0);
        reset_n <= 1'b1;
        // One edge for the reset exception; the next edge executes word 0
        @(posedge clk);
        #1;
        check("first req", {31'h0, mem_req}, 32'h1);
        check("first fetch", mem_addr, `RCCE_VEC_RESET);
        check("first be", {28'h0, mem_be}, 32'hF);
        wait_doze(1'b1);
        check("bus cycles", xfers, 32'h13);
        check("doze req", {31'h0, mem_req}, 32'h0);
        check("word", u_rcce_mem.mem[256], 32'h1234_5678);
        check("byte", u_rcce_mem.mem[257], 32'h0078_0000);
        check("half", u_rcce_mem.mem[258], 32'h0000_5678);
        check("fault", u_rcce_mem.mem[259], 32'hFFFF_8000);
        @(posedge clk);
        irq <= 1'b1;
        wait_doze(1'b0);
        check("irq vector", mem_addr, `RCCE_VEC_IRQ);
        @(posedge clk);
        irq <= 1'b0;
        wait_doze(1'b1);
        check("saved pc", u_rcce_mem.mem[260], 32'h0000_0114);
        $display("test_program slow=%0d done", s);
    endtask
    initial begin
        test_program(1'b0);
        test_program(1'b1);
        close_out();
    end
endmodule
